/* File: common/crms_pkg.sv */
// Package for the counter reload mode sequencer: widths, reset values,
// mode enumerations and the structs that carry configuration and commands.
// Assumes one 100 MHz clock domain shared by all users of these types.
package crms_pkg;

    // Counter and register width
    localparam int                COUNT_W        = 16;

    // Reset values
    localparam logic [COUNT_W-1:0] COUNT_RESET   = 16'h0000;
    localparam logic [COUNT_W-1:0] LOAD_RESET    = 16'h0000;
    localparam logic [COUNT_W-1:0] HOLD_RESET    = 16'h0000;

    // Count value on which a counted edge is a terminal count
    localparam logic [COUNT_W-1:0] TERMINAL_VALUE = 16'h0001;
    localparam logic [COUNT_W-1:0] COUNT_STEP     = 16'h0001;

    // Pin synchroniser depth
    localparam int                SYNC_STAGES    = 2;

    // Gating-control field
    typedef enum logic [2:0] {
        GATE_NONE  = 3'b001,
        GATE_LEVEL = 3'b010,
        GATE_EDGE  = 3'b100
    } crms_gating_e;

    // Reload-behaviour field
    typedef enum logic [2:0] {
        RELOAD_DELAYED   = 3'b001,
        RELOAD_ALTERNATE = 3'b010,
        RELOAD_RETRIGGER = 3'b100
    } crms_reload_e;

    // Counter mode configuration
    typedef struct packed {
        crms_gating_e gating;
        crms_reload_e reload;
    } crms_cfg_s;

    // Host commands and register writes, one-cycle strobes
    typedef struct packed {
        logic               arm;
        logic               disarm;
        logic               load;
        logic               loadWrite;
        logic               holdWrite;
        logic [COUNT_W-1:0] data;
    } crms_cmd_s;

    // Whole state of the sequencer
    typedef struct packed {
        logic [SYNC_STAGES-1:0] sourceSync;
        logic [SYNC_STAGES-1:0] gateSync;
        logic                   sourceLast;
        logic                   gateLast;
        logic [COUNT_W-1:0]     count;
        logic [COUNT_W-1:0]     loadReg;
        logic [COUNT_W-1:0]     holdReg;
        logic                   armed;
        logic                   triggered;
        logic                   secondHalf;
        logic                   retrigPending;
        logic                   tcState;
        logic                   pendDisarm;
        logic                   pendStop;
        logic                   terminalCountEvent;
        logic                   toggleOnTerminalCount;
    } crms_state_s;

endpackage : crms_pkg

/* File: design/crms_sequencer.sv */
// Per-counter reload mode sequencer: decides when source edges count,
// arming and disarming, reload source at terminal count, gate-edge saves.
// Assumes source and gate arrive as asynchronous pins, and host commands
// arrive as one-cycle strobes in the clock domain.
//
// Contract
// - Level-gated delayed pulse: count gated, armed only
// - Delayed pulse: hold reload, then load and disarm
// - Edge delayed strobe: trigger only when armed
// - Edge delayed strobe: gate ignored until second TC
// - Edge delayed strobe disarms; rearm then gate edge
// - Ungated alternate mode runs until disarm command
// - Alternate modes: odd TC hold, even TC load
// - Level-gated alternate mode counts only with gate
// - Arm restarts alternation with hold register
// - Edge one-shot: trigger starts, gate then ignored
// - Edge one-shot: first TC reloads from hold
// - Edge one-shot: second TC loads, stops, stays armed
// - Retrigger strobe: TC reloads load and disarms
// - Retrigger strobe: gate edge to armed counter saves count
// - After retrigger: load first, decrement second edge
// - Qualified edge: source rise, with gate active in level gating
// - TC state always counts; stop follows leaving edge
// - Only active-going edges count or trigger
// - Load command copies load register into counter
`timescale 1ns/1ps

module crms_sequencer (
    // Clock and reset
    input  wire logic                       clock,
    input  wire logic                       nrst,
    // Counter mode configuration
    input  wire crms_pkg::crms_cfg_s        cfg,
    // Host commands
    input  wire crms_pkg::crms_cmd_s        cmd,
    // External pins
    input  wire logic                       sourcePin,
    input  wire logic                       gatePin,
    // Counter contents
    output logic [crms_pkg::COUNT_W-1:0]    count,
    output logic [crms_pkg::COUNT_W-1:0]    loadReg,
    output logic [crms_pkg::COUNT_W-1:0]    holdReg,
    // Status
    output logic                            armed,
    output logic                            triggered,
    output logic                            tcState,
    // Terminal count indications
    output logic                            terminalCountEvent,
    output logic                            toggleOnTerminalCount
);
    import crms_pkg::*;

    logic        rstSync1;
    logic        rstSyncN;

    crms_state_s state;
    crms_state_s next_state;

    // Reset release held back two edges so all flops leave reset together
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rstSync1 <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSyncN <= rstSync1;
        end
    end

    // Combinational next state
    always_comb begin
        logic sourceLevel;
        logic gateLevel;
        logic sourceEdge;
        logic gateEdge;
        logic qualified;
        logic gateAllows;
        logic countEnable;
        logic edgeGated;
        logic retrigEvent;
        logic trigEvent;

        next_state  = state;
        sourceLevel = state.sourceSync[SYNC_STAGES-1];
        gateLevel   = state.gateSync[SYNC_STAGES-1];
        sourceEdge  = 1'b0;
        gateEdge    = 1'b0;
        qualified   = 1'b0;
        gateAllows  = 1'b0;
        countEnable = 1'b0;
        edgeGated   = (cfg.gating == GATE_EDGE);
        retrigEvent = 1'b0;
        trigEvent   = 1'b0;

        // Pin synchronisers; first stage feeds only the second
        next_state.sourceSync = {state.sourceSync[SYNC_STAGES-2:0], sourcePin};
        next_state.gateSync   = {state.gateSync[SYNC_STAGES-2:0], gatePin};
        next_state.sourceLast = sourceLevel;
        next_state.gateLast   = gateLevel;
        next_state.terminalCountEvent = 1'b0;

        sourceEdge = sourceLevel & ~state.sourceLast;
        gateEdge   = gateLevel & ~state.gateLast;

        // Gate events decided once, so a later clear cannot undo them
        retrigEvent = gateEdge & state.armed & (cfg.reload == RELOAD_RETRIGGER);
        trigEvent   = gateEdge & state.armed & edgeGated & ~state.triggered
                      & (cfg.reload != RELOAD_RETRIGGER);

        case (cfg.gating)
            GATE_NONE: begin
                gateAllows = 1'b1;
            end
            GATE_LEVEL: begin
                gateAllows = gateLevel;
            end
            GATE_EDGE: begin
                // after trigger gate level is ignored
                gateAllows = state.triggered;
            end
            default: begin
                gateAllows = 1'b0;
            end
        endcase

        // qualified edge needs active gate in level gating
        qualified   = sourceEdge & ((cfg.gating != GATE_LEVEL) | gateLevel);
        countEnable = state.armed & gateAllows;

        // Host register writes
        if (cmd.loadWrite) begin
            next_state.loadReg = cmd.data;
        end
        if (cmd.holdWrite) begin
            next_state.holdReg = cmd.data;
        end

        // Gate edge handling
        if (gateEdge && state.armed) begin
            if (cfg.reload == RELOAD_RETRIGGER) begin
                // save count on every gate edge; wins over host write
                next_state.holdReg       = state.count;
                next_state.retrigPending = 1'b1;
                next_state.triggered     = 1'b1;
            end else if (edgeGated && !state.triggered) begin
                // trigger only an armed, idle counter
                next_state.triggered  = 1'b1;
                // first TC after trigger uses hold
                next_state.secondHalf = 1'b0;
            end
        end

        // Source edge handling
        if (sourceEdge && state.tcState) begin
            // leaving TC counts regardless of gate or arm
            next_state.count   = state.count - COUNT_STEP;
            next_state.tcState = 1'b0;
            if (state.pendDisarm) begin
                next_state.armed         = 1'b0;
                next_state.triggered     = 1'b0;
                next_state.retrigPending = 1'b0;
            end
            if (state.pendStop) begin
                next_state.triggered = 1'b0;
            end
            next_state.pendDisarm = 1'b0;
            next_state.pendStop   = 1'b0;
        end else if (qualified && countEnable) begin
            if (state.retrigPending) begin
                // first qualified edge loads, next decrements
                next_state.count         = state.loadReg;
                // Set wins: a retrigger in this cycle keeps its pending load
                next_state.retrigPending = retrigEvent;
            end else if (state.count == TERMINAL_VALUE) begin
                next_state.terminalCountEvent    = 1'b1;
                next_state.toggleOnTerminalCount = ~state.toggleOnTerminalCount;
                next_state.tcState               = 1'b1;
                case (cfg.reload)
                    RELOAD_DELAYED: begin
                        // hold first, then load and disarm
                        if (!state.secondHalf) begin
                            next_state.count      = state.holdReg;
                            next_state.secondHalf = 1'b1;
                        end else begin
                            next_state.count      = state.loadReg;
                            next_state.secondHalf = 1'b0;
                            next_state.pendDisarm = 1'b1;
                        end
                    end
                    RELOAD_ALTERNATE: begin
                        // odd TC hold, even TC load
                        if (!state.secondHalf) begin
                            next_state.count      = state.holdReg;
                            next_state.secondHalf = 1'b1;
                        end else begin
                            next_state.count      = state.loadReg;
                            next_state.secondHalf = 1'b0;
                            next_state.pendStop   = edgeGated;
                        end
                    end
                    RELOAD_RETRIGGER: begin
                        next_state.count      = state.loadReg;
                        next_state.pendDisarm = 1'b1;
                    end
                    default: begin
                        next_state.count = state.loadReg;
                    end
                endcase
            end else begin
                next_state.count = state.count - COUNT_STEP;
            end
        end

        // load command sets the initial count
        if (cmd.load) begin
            next_state.count         = state.loadReg;
            next_state.retrigPending = retrigEvent;
        end

        // Commands; disarm wins over a simultaneous arm
        if (cmd.disarm) begin
            if (state.tcState && !(sourceEdge)) begin
                // disarm waits until TC is left
                next_state.pendDisarm = 1'b1;
            end else begin
                next_state.armed         = 1'b0;
                next_state.triggered     = 1'b0;
                next_state.retrigPending = 1'b0;
            end
        end else if (cmd.arm) begin
            // arm needed before trigger or count
            next_state.armed      = 1'b1;
            next_state.secondHalf = 1'b0;
            next_state.pendDisarm = 1'b0;
            if (edgeGated && cfg.reload != RELOAD_ALTERNATE) begin
                // Fresh arm waits for a new trigger; one in this cycle stands
                next_state.triggered = trigEvent;
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state <= '{
                sourceSync:            '0,
                gateSync:              '0,
                sourceLast:            1'b0,
                gateLast:              1'b0,
                count:                 COUNT_RESET,
                loadReg:               LOAD_RESET,
                holdReg:               HOLD_RESET,
                armed:                 1'b0,
                triggered:             1'b0,
                secondHalf:            1'b0,
                retrigPending:         1'b0,
                tcState:               1'b0,
                pendDisarm:            1'b0,
                pendStop:              1'b0,
                terminalCountEvent:    1'b0,
                toggleOnTerminalCount: 1'b0
            };
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from state flops
    assign count                 = state.count;
    assign loadReg               = state.loadReg;
    assign holdReg               = state.holdReg;
    assign armed                 = state.armed;
    assign triggered             = state.triggered;
    assign tcState               = state.tcState;
    assign terminalCountEvent    = state.terminalCountEvent;
    assign toggleOnTerminalCount = state.toggleOnTerminalCount;

endmodule : crms_sequencer

/* File: verification/crms_pin_model.sv */
// Pin-side model: source pulses and gate levels for the sequencer.
// Assumes calls come from the sequencer clock domain.
`timescale 1ns/1ps

module crms_pin_model (
    // Clock
    input  wire logic clock,
    // Driven pins
    output logic      sourcePin,
    output logic      gatePin
);
    initial begin
        sourcePin = 1'b0;
        gatePin = 1'b0;
    end
    // Four cycles high, five low between pulses, above the three-cycle minimum
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clock) sourcePin <= 1'b1;
            repeat (4) @(posedge clock);
            sourcePin <= 1'b0;
            repeat (4) @(posedge clock);
        end
        #1;
    endtask : pulse
    task automatic gate(input logic v);
        @(posedge clock) gatePin <= v;
        repeat (5) @(posedge clock);
        #1;
    endtask : gate
endmodule : crms_pin_model

/* File: verification/crms_sequencer_asserts.sv */
// Checker for the reload mode sequencer, bound to its top-level ports.
// Assumes one-cycle command strobes and pin levels held three cycles.
`timescale 1ns/1ps

module crms_sequencer_asserts (
    // Clock and reset
    input wire logic                         clock,
    input wire logic                         nrst,
    // Controls and pins
    input wire crms_pkg::crms_cfg_s          cfg,
    input wire crms_pkg::crms_cmd_s          cmd,
    input wire logic                         sourcePin,
    input wire logic                         gatePin,
    // Counter and status
    input wire logic [crms_pkg::COUNT_W-1:0] count,
    input wire logic [crms_pkg::COUNT_W-1:0] loadReg,
    input wire logic [crms_pkg::COUNT_W-1:0] holdReg,
    input wire logic                         armed,
    input wire logic                         triggered,
    input wire logic                         tcState,
    input wire logic                         terminalCountEvent,
    input wire logic                         toggleOnTerminalCount
);
    import crms_pkg::*;
    default clocking dc @(posedge clock); endclocking
    default disable iff (!nrst);
    a_toggle_follows: assert property (
        terminalCountEvent == $changed(toggleOnTerminalCount))
        else $error("toggle and terminal count disagree");
    a_reload_value: assert property (terminalCountEvent |->
        count == $past(holdReg) || count == $past(loadReg)) else $error("bad reload value");
    a_event_spacing: assert property (terminalCountEvent |=> !terminalCountEvent [*4])
        else $error("terminal count pulse too wide");
    a_load_copies: assert property (cmd.load && !cmd.loadWrite |=>
        count == $past(loadReg)) else $error("load command missed");
    a_disarm_now: assert property (cmd.disarm && !tcState |=> !armed)
        else $error("disarm command missed");
    a_arm_now: assert property (cmd.arm && !cmd.disarm && !tcState |=> armed)
        else $error("arm command missed");
    a_count_cause: assert property ($changed(count) |->
        $past(armed) || $past(tcState) || $past(cmd.load)) else $error("count moved while idle");
    a_save_hold: assert property ($changed(holdReg) && !$past(cmd.holdWrite) |->
        holdReg == $past(count)) else $error("hold save wrong");
    a_trigger_armed: assert property ($rose(triggered) |-> $past(armed))
        else $error("trigger while disarmed");
    a_event_enters_tc: assert property (terminalCountEvent |-> tcState)
        else $error("terminal count without terminal state");
    c_terminal: cover property (terminalCountEvent);
    c_deferred: cover property (cmd.disarm && tcState);
    c_saved: cover property ($changed(holdReg) && !$past(cmd.holdWrite));
    c_stopped: cover property ($fell(triggered) && armed);
endmodule : crms_sequencer_asserts

bind crms_sequencer crms_sequencer_asserts u_crms_sequencer_asserts (.clock(clock),
    .nrst(nrst), .cfg(cfg), .cmd(cmd), .sourcePin(sourcePin), .gatePin(gatePin),
    .count(count), .loadReg(loadReg), .holdReg(holdReg), .armed(armed), .triggered(triggered),
    .tcState(tcState), .terminalCountEvent(terminalCountEvent),
    .toggleOnTerminalCount(toggleOnTerminalCount));

/* File: verification/crms_sequencer_tb_top.sv */
// Testbench for the reload mode sequencer: one task for each of six counting modes.
// Assumes the pin model settles every pin effect before it returns.
`timescale 1ns/1ps

module crms_sequencer_tb_top;
    import crms_pkg::*;
    localparam logic [4:0] ARM = 5'h10, DIS = 5'h08, LD = 5'h04, WL = 5'h02, WH = 5'h01;
    logic               clock = 1'b0;
    logic               nrst = 1'b0;
    crms_cfg_s          cfg;
    crms_cmd_s          cmd;
    logic               sourcePin, gatePin, armed, triggered, tcState, endEvent, endToggle;
    logic [COUNT_W-1:0] count, loadReg, holdReg;
    int                 failures = 0;
    int                 compares = 0;
    int                 tcEvents = 0;
    // Counted per edge, so a pulse standing two cycles counts twice
    always @(posedge clock) begin
        if (endEvent === 1'b1) begin
            tcEvents++;
        end
    end
    always #5 clock = ~clock;
    crms_sequencer u_crms_sequencer (.clock(clock), .nrst(nrst), .cfg(cfg), .cmd(cmd),
        .sourcePin(sourcePin), .gatePin(gatePin), .count(count), .loadReg(loadReg),
        .holdReg(holdReg), .armed(armed), .triggered(triggered), .tcState(tcState),
        .terminalCountEvent(endEvent), .toggleOnTerminalCount(endToggle));
    crms_pin_model u_crms_pin_model (.clock(clock), .sourcePin(sourcePin), .gatePin(gatePin));
    task automatic chk(input logic [COUNT_W-1:0] got, input logic [COUNT_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic op(input logic [4:0] f, input logic [COUNT_W-1:0] d);
        @(posedge clock) cmd <= {f, d};
        @(posedge clock) cmd <= '0;
        #1;
    endtask : op
    task automatic src(input int n);
        u_crms_pin_model.pulse(n);
    endtask : src
    task automatic gt(input logic v);
        u_crms_pin_model.gate(v);
    endtask : gt
    task automatic setup(input crms_cfg_s m, input logic [COUNT_W-1:0] ld, hd);
        op(DIS, 16'h0000);
        @(posedge clock) cfg <= m;
        op(WL, ld);
        op(WH, hd);
        op(LD, 16'h0000);
        chk(loadReg, ld);
        chk(count, ld);
    endtask : setup
    task automatic runAlternate();
        int   base;
        logic tog;
        base = tcEvents;
        tog  = endToggle;
        setup(crms_cfg_s'{GATE_NONE, RELOAD_ALTERNATE}, 16'h0002, 16'h0003);
        op(ARM, 16'h0000);
        src(2);
        chk(count, 16'h0003);
        chk(16'(tcState), 16'h0001);
        chk(16'(tcEvents - base), 16'h0001);
        chk(16'(endToggle ^ tog), 16'h0001);
        src(3);
        chk(count, 16'h0002);
        chk(16'(tcEvents - base), 16'h0002);
        chk(16'(endToggle ^ tog), 16'h0000);
        // Disarm lands in the terminal state, so it waits for the leaving edge
        op(DIS, 16'h0000);
        chk(16'(armed), 16'h0001);
        src(1);
        chk(count, 16'h0001);
        chk(16'(armed), 16'h0000);
        src(1);
        chk(count, 16'h0001);
    endtask : runAlternate
    task automatic runLevelDelayed();
        setup(crms_cfg_s'{GATE_LEVEL, RELOAD_DELAYED}, 16'h0002, 16'h0003);
        src(1);
        gt(1'b1);
        src(1);
        chk(count, 16'h0002);
        op(ARM, 16'h0000);
        gt(1'b0);
        src(1);
        chk(count, 16'h0002);
        gt(1'b1);
        src(2);
        chk(count, 16'h0003);
        src(3);
        chk(count, 16'h0002);
        chk(16'(armed), 16'h0001);
        src(1);
        chk(16'(armed), 16'h0000);
        src(1);
        chk(count, 16'h0001);
        gt(1'b0);
    endtask : runLevelDelayed
    task automatic runLevelAlternate();
        setup(crms_cfg_s'{GATE_LEVEL, RELOAD_ALTERNATE}, 16'h0002, 16'h0003);
        op(ARM, 16'h0000);
        src(2);
        chk(count, 16'h0002);
        gt(1'b1);
        src(4);
        chk(count, 16'h0001);
        op(ARM, 16'h0000);
        src(1);
        chk(count, 16'h0003);
        src(1);
        gt(1'b0);
    endtask : runLevelAlternate
    task automatic runEdgeDelayed();
        setup(crms_cfg_s'{GATE_EDGE, RELOAD_DELAYED}, 16'h0002, 16'h0003);
        gt(1'b1);
        gt(1'b0);
        src(1);
        chk(count, 16'h0002);
        chk(16'(triggered), 16'h0000);
        op(ARM, 16'h0000);
        gt(1'b1);
        chk(16'(triggered), 16'h0001);
        src(2);
        chk(count, 16'h0003);
        gt(1'b0);
        gt(1'b1);
        src(3);
        chk(count, 16'h0002);
        src(1);
        chk(16'(armed), 16'h0000);
        chk(16'(triggered), 16'h0000);
        src(1);
        chk(count, 16'h0001);
        gt(1'b0);
        // Arm alone does not restart; the gate edge after it does
        op(ARM, 16'h0000);
        src(1);
        chk(count, 16'h0001);
        gt(1'b1);
        src(2);
        chk(count, 16'h0002);
        gt(1'b0);
    endtask : runEdgeDelayed
    task automatic runOneShot();
        setup(crms_cfg_s'{GATE_EDGE, RELOAD_ALTERNATE}, 16'h0002, 16'h0003);
        op(ARM, 16'h0000);
        gt(1'b1);
        src(2);
        chk(count, 16'h0003);
        gt(1'b0);
        gt(1'b1);
        src(3);
        chk(count, 16'h0002);
        src(2);
        chk(count, 16'h0001);
        chk(16'(armed), 16'h0001);
        chk(16'(triggered), 16'h0000);
        gt(1'b0);
        gt(1'b1);
        src(1);
        chk(count, 16'h0003);
        src(1);
        gt(1'b0);
    endtask : runOneShot
    task automatic runRetrigger();
        setup(crms_cfg_s'{GATE_LEVEL, RELOAD_RETRIGGER}, 16'h0005, 16'h0000);
        op(WL, 16'h0007);
        op(ARM, 16'h0000);
        gt(1'b1);
        chk(holdReg, 16'h0005);
        src(1);
        chk(count, 16'h0007);
        src(1);
        chk(count, 16'h0006);
        src(6);
        chk(count, 16'h0007);
        src(2);
        chk(count, 16'h0006);
        chk(16'(armed), 16'h0000);
        gt(1'b0);
    endtask : runRetrigger
    task automatic results();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    initial begin
        cfg = '{GATE_NONE, RELOAD_DELAYED};
        cmd = '0;
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        runAlternate();
        runLevelDelayed();
        runLevelAlternate();
        runEdgeDelayed();
        runOneShot();
        runRetrigger();
        results();
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        results();
    end
endmodule : crms_sequencer_tb_top
